// ### rtl/seg_addr_gen.sv
`timescale 1ns/100ps
module seg_addr_gen (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic CE,
   // Request from decode/execute
   input wire logic REQ_VALID,
   input wire logic [2:0] REF_TYPE,
   input wire logic [2:0] BASE_REG,
   input wire logic OVR_VALID,
   input wire logic [2:0] OVR_SEG,
   input wire logic [31:0] OFFSET,
   input wire logic REAL_MODE,
   // Segment state: selectors, protected-mode bases, limits
   input wire logic [95:0] SEL_ALL,
   input wire logic [191:0] BASE_ALL,
   input wire logic [191:0] LIMIT_ALL,
   // I/O port source
   input wire logic PORT_FROM_IMM,
   input wire logic [7:0] PORT_IMM,
   input wire logic [15:0] PORT_INDEX_REG,
   // Bus side
   output logic ADDR_VALID,
   output logic [31:0] ADDR,
   output logic MEM_IO_N,
   output logic [2:0] SEG_USED,
   output logic LIMIT_FAULT,
   output logic RSVD_PORT
);
   import segsel_pkg::*;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic mem_io_n;
      logic [2:0] seg;
      logic fault;
      logic rsvd;
   } state_s;

   state_s st_q, st_d;
   segsel_if sif ();
   logic [15:0] sel_cur;
   logic [31:0] base_cur, limit_cur, lin_addr;
   logic [15:0] port_addr;

   //////////////////////////////////////////////////////////////////////////
   // Segment selection
   assign sif.ref_type = REF_TYPE;
   assign sif.base_reg = BASE_REG;
   assign sif.ovr_valid = OVR_VALID;
   assign sif.ovr_seg = OVR_SEG;

   seg_chooser u_chooser (
      .sif(sif.chooser)
   );

   // Selector of one segment code out of the packed selector bank
   function automatic logic [15:0] pick_sel(input logic [95:0] bank, input logic [2:0] idx);
      return bank[idx*16 +: 16];
   endfunction

   // One 32-bit word of one segment code out of a packed base or limit bank
   function automatic logic [31:0] pick_word(input logic [191:0] bank, input logic [2:0] idx);
      return bank[idx*32 +: 32];
   endfunction

   // Pick the chosen segment's state by index
   always_comb begin
      sel_cur = pick_sel(SEL_ALL, sif.seg_sel);
      base_cur = pick_word(BASE_ALL, sif.seg_sel);
      limit_cur = pick_word(LIMIT_ALL, sif.seg_sel);
   end

   // Linear address: real mode shifts selector, else descriptor base
   always_comb begin
      if (REAL_MODE) begin
         lin_addr = {12'h000, sel_cur, 4'h0} + OFFSET;
      end else begin
         lin_addr = base_cur + OFFSET;
      end
   end

   // Port address from immediate or index register, zero-extended
   always_comb begin
      if (PORT_FROM_IMM) begin
         port_addr = {8'h00, PORT_IMM};
      end else begin
         port_addr = PORT_INDEX_REG;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_d = st_q;
      st_d.valid = REQ_VALID;
      if (REQ_VALID) begin
         if (REF_TYPE == REF_IO) begin
            st_d.addr = {16'h0000, port_addr};
            st_d.mem_io_n = 1'b0;
            st_d.fault = 1'b0;
            st_d.rsvd = port_addr[15:8] == 8'h00 && port_addr[7:0] >= RSVD_PORT_LO
               && port_addr[7:0] <= RSVD_PORT_HI;
         end else begin
            st_d.addr = lin_addr;
            st_d.mem_io_n = 1'b1;
            st_d.seg = sif.seg_sel;
            st_d.fault = !REAL_MODE && (OFFSET > limit_cur);
            st_d.rsvd = 1'b0;
         end
      end
   end

   // State register
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         st_q <= '{valid: 1'b0, addr: ADDR_RST, mem_io_n: 1'b1, seg: SEG_CODE, fault: SEG_LIMIT_RST, rsvd: 1'b0};
      end else if (CE) begin
         st_q <= st_d;
      end
   end

   assign ADDR_VALID = st_q.valid;
   assign ADDR = st_q.addr;
   assign MEM_IO_N = st_q.mem_io_n;
   assign SEG_USED = st_q.seg;
   assign LIMIT_FAULT = st_q.fault;
   assign RSVD_PORT = st_q.rsvd;

   //////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_io_req;
      CE && REQ_VALID && REF_TYPE == REF_IO;
   endsequence

   // A taken memory request of any reference type
   sequence s_mem_req;
      CE && REQ_VALID && REF_TYPE != REF_IO;
   endsequence

   // A taken memory request outside real mode
   sequence s_prot_req;
      s_mem_req ##0 !REAL_MODE;
   endsequence

   // A taken I/O request whose port comes from the index register
   sequence s_io_index_req;
      s_io_req ##0 !PORT_FROM_IMM;
   endsequence

   // A taken I/O request whose port comes from the immediate byte
   sequence s_io_imm_req;
      s_io_req ##0 PORT_FROM_IMM;
   endsequence

   property p_io_pin;
      @(posedge CLK_SYS) disable iff (RST) s_io_req |=> !MEM_IO_N && ADDR[31:16] == 16'h0000;
   endproperty
   a_io_pin: assert property (p_io_pin) else $error("I/O cycle not low or not zero-extended");

   property p_code;
      @(posedge CLK_SYS) disable iff (RST) CE && REQ_VALID && REF_TYPE == REF_CODE |=> SEG_USED == SEG_CODE;
   endproperty
   a_code: assert property (p_code) else $error("Code fetch not in code segment");

   property p_stack_ops;
      @(posedge CLK_SYS) disable iff (RST)
         CE && REQ_VALID && (REF_TYPE == REF_PUSH || REF_TYPE == REF_POP) |=> SEG_USED == SEG_STACK;
   endproperty
   a_stack_ops: assert property (p_stack_ops) else $error("Push/pop not in stack segment");

   property p_strdst;
      @(posedge CLK_SYS) disable iff (RST) CE && REQ_VALID && REF_TYPE == REF_STRDST |=> SEG_USED == SEG_EXTRA;
   endproperty
   a_strdst: assert property (p_strdst) else $error("String destination not in extra segment");

   property p_override;
      @(posedge CLK_SYS) disable iff (RST)
         CE && REQ_VALID && REF_TYPE == REF_DATA && OVR_VALID |=> SEG_USED == $past(OVR_SEG);
   endproperty
   a_override: assert property (p_override) else $error("Override segment not applied");

   property p_default_data;
      @(posedge CLK_SYS) disable iff (RST) CE && REQ_VALID && REF_TYPE == REF_DATA && !OVR_VALID
         |=> SEG_USED == (($past(BASE_REG) == BASE_FRAME || $past(BASE_REG) == BASE_STACK) ? SEG_STACK : SEG_DATA);
   endproperty
   a_default_data: assert property (p_default_data) else $error("Wrong default data segment");

   property p_real_addr;
      @(posedge CLK_SYS) disable iff (RST) CE && REQ_VALID && REAL_MODE && REF_TYPE != REF_IO
         |=> ADDR == {12'h000, $past(sel_cur), 4'h0} + $past(OFFSET);
   endproperty
   a_real_addr: assert property (p_real_addr) else $error("Real mode address wrong");

   property p_io_imm;
      @(posedge CLK_SYS) disable iff (RST) s_io_imm_req |=> ADDR == {24'h000000, $past(PORT_IMM)};
   endproperty
   a_io_imm: assert property (p_io_imm) else $error("Immediate port address wrong");

   property p_mem_high;
      @(posedge CLK_SYS) disable iff (RST) CE && REQ_VALID && REF_TYPE != REF_IO |=> MEM_IO_N;
   endproperty
   a_mem_high: assert property (p_mem_high) else $error("Memory cycle marked as I/O");

   // Index-register port goes out zero-extended, untranslated
   property p_io_index;
      @(posedge CLK_SYS) disable iff (RST) s_io_index_req |=> ADDR == {16'h0000, $past(PORT_INDEX_REG)};
   endproperty
   a_io_index: assert property (p_io_index) else $error("Index port address wrong");

   // Port cycles never raise a limit fault and leave the segment alone
   property p_io_no_seg;
      @(posedge CLK_SYS) disable iff (RST) s_io_req |=> !LIMIT_FAULT && $stable(SEG_USED);
   endproperty
   a_io_no_seg: assert property (p_io_no_seg) else $error("I/O cycle touched segment state");

   // Reserved port window flagged on port cycles
   property p_rsvd;
      @(posedge CLK_SYS) disable iff (RST) s_io_req
         |=> RSVD_PORT == (ADDR[15:8] == 8'h00 && ADDR[7:0] >= RSVD_PORT_LO && ADDR[7:0] <= RSVD_PORT_HI);
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("Reserved port flag wrong");

   // Protected mode: descriptor base plus offset, unpaged
   property p_prot_addr;
      @(posedge CLK_SYS) disable iff (RST) s_prot_req |=> ADDR == $past(base_cur) + $past(OFFSET);
   endproperty
   a_prot_addr: assert property (p_prot_addr) else $error("Protected mode address wrong");

   // Limit fault only when the offset passes the last valid byte
   property p_limit;
      @(posedge CLK_SYS) disable iff (RST) s_prot_req |=> LIMIT_FAULT == ($past(OFFSET) > $past(limit_cur));
   endproperty
   a_limit: assert property (p_limit) else $error("Limit fault wrong");

   // Real mode never faults on the limit
   property p_real_no_fault;
      @(posedge CLK_SYS) disable iff (RST) s_mem_req ##0 REAL_MODE |=> !LIMIT_FAULT;
   endproperty
   a_real_no_fault: assert property (p_real_no_fault) else $error("Limit fault in real mode");

   // Answer strobe follows a taken request by one cycle
   property p_valid;
      @(posedge CLK_SYS) disable iff (RST) CE |=> ADDR_VALID == $past(REQ_VALID);
   endproperty
   a_valid: assert property (p_valid) else $error("Answer strobe does not follow request");

   // Clock enable low freezes every output
   property p_freeze;
      @(posedge CLK_SYS) disable iff (RST) !CE
         |=> $stable(ADDR_VALID) && $stable(ADDR) && $stable(MEM_IO_N) && $stable(SEG_USED)
            && $stable(LIMIT_FAULT) && $stable(RSVD_PORT);
   endproperty
   a_freeze: assert property (p_freeze) else $error("Outputs moved while clock enable low");
endmodule // seg_addr_gen

// ### pkg/segsel_pkg.sv
package segsel_pkg;
   // Segment register codes
   typedef enum logic [2:0] {
      SEG_EXTRA = 3'b000,
      SEG_CODE = 3'b001,
      SEG_STACK = 3'b010,
      SEG_DATA = 3'b011,
      SEG_EXTRA2 = 3'b100,
      SEG_EXTRA3 = 3'b101
   } seg_e;

   // Reference types issued by decode/execute
   typedef enum logic [2:0] {
      REF_CODE = 3'b000,
      REF_PUSH = 3'b001,
      REF_POP = 3'b010,
      REF_STRDST = 3'b011,
      REF_DATA = 3'b100,
      REF_IO = 3'b101
   } ref_e;

   // Base register codes
   localparam logic [2:0] BASE_FRAME = 3'h5;
   localparam logic [2:0] BASE_STACK = 3'h4;

   // I/O space and address formation
   localparam int IO_ADDR_W = 16;
   localparam int IMM_PORT_W = 8;
   localparam int REAL_SHIFT = 4;
   localparam int ADDR_W = 32;
   localparam logic [31:0] ADDR_RST = 32'h0000_0000;
   localparam logic SEG_LIMIT_RST = 1'b0;
   localparam logic [7:0] RSVD_PORT_LO = 8'hf8;
   localparam logic [7:0] RSVD_PORT_HI = 8'hff;
endpackage

// ### pkg/segsel_if.sv
`timescale 1ns/100ps
interface segsel_if;
   import segsel_pkg::*;
   logic [2:0] ref_type;
   logic [2:0] base_reg;
   logic ovr_valid;
   logic [2:0] ovr_seg;
   logic [2:0] seg_sel;
   logic override_used;
   modport chooser (input ref_type, base_reg, ovr_valid, ovr_seg, output seg_sel, override_used);
   modport user (output ref_type, base_reg, ovr_valid, ovr_seg, input seg_sel, override_used);
endinterface // segsel_if

// ### rtl/seg_chooser.sv
`timescale 1ns/100ps
module seg_chooser (
   // Selection request and answer
   segsel_if.chooser sif
);
   import segsel_pkg::*;

   //////////////////////////////////////////////////////////////////////////
   // Default segment per reference type, then override where legal
   always_comb begin
      sif.override_used = 1'b0;
      case (ref_e'(sif.ref_type))
         REF_CODE: sif.seg_sel = SEG_CODE;
         REF_PUSH, REF_POP: sif.seg_sel = SEG_STACK;
         REF_STRDST: sif.seg_sel = SEG_EXTRA;
         REF_DATA: begin
            if (sif.ovr_valid) begin
               sif.seg_sel = sif.ovr_seg;
               sif.override_used = 1'b1;
            end else if (sif.base_reg == BASE_FRAME || sif.base_reg == BASE_STACK) begin
               sif.seg_sel = SEG_STACK;
            end else begin
               sif.seg_sel = SEG_DATA;
            end
         end
         default: sif.seg_sel = SEG_DATA;
      endcase
   end
endmodule // seg_chooser

// ### tb/bus_decoder_model.sv
`timescale 1ns/100ps
module bus_decoder_model (
   // Bus side of the address generator
   input wire logic clk,
   input wire logic addr_valid,
   input wire logic [31:0] addr,
   input wire logic mem_io_n,
   // Space decoded for the previous cycle
   output logic io_hit,
   output logic mem_hit
);
   // Ports decode lines 31..3; no peripheral sits in the reserved 00f8..00ff range
   always_ff @(posedge clk) begin
      io_hit <= addr_valid && !mem_io_n && addr[31:16] == 16'h0000 && addr[15:3] != 13'h001f;
      mem_hit <= addr_valid && mem_io_n;
   end
endmodule // bus_decoder_model

// ### tb/tb.sv
`timescale 1ns/100ps
module tb;
   import segsel_pkg::*;
   logic clk_sys = 0, rst = 1, ce = 1, req_valid = 0, ovr_valid = 0, real_mode = 0, port_from_imm = 0;
   logic [2:0] ref_type = 0, base_reg = 0, ovr_seg = 0;
   logic [31:0] offset = 0;
   logic [95:0] sel_all = {16'h5555, 16'h4444, 16'h3333, 16'h2222, 16'h1111, 16'h0abc};
   logic [191:0] base_all = '0, limit_all = '1;
   logic [7:0] port_imm = 0;
   logic [15:0] port_index_reg = 0;
   logic addr_valid, mem_io_n, limit_fault, rsvd_port, io_hit, mem_hit;
   logic [31:0] addr;
   logic [2:0] seg_used;
   int fail_count = 0, checks = 0;
   seg_addr_gen seg_addr_gen_i (.CLK_SYS(clk_sys), .RST(rst), .CE(ce), .REQ_VALID(req_valid),
      .REF_TYPE(ref_type), .BASE_REG(base_reg), .OVR_VALID(ovr_valid), .OVR_SEG(ovr_seg), .OFFSET(offset),
      .REAL_MODE(real_mode), .SEL_ALL(sel_all), .BASE_ALL(base_all), .LIMIT_ALL(limit_all),
      .PORT_FROM_IMM(port_from_imm), .PORT_IMM(port_imm), .PORT_INDEX_REG(port_index_reg),
      .ADDR_VALID(addr_valid), .ADDR(addr), .MEM_IO_N(mem_io_n), .SEG_USED(seg_used),
      .LIMIT_FAULT(limit_fault), .RSVD_PORT(rsvd_port));
   bus_decoder_model bus_decoder_model_i (.clk(clk_sys), .addr_valid(addr_valid), .addr(addr),
      .mem_io_n(mem_io_n), .io_hit(io_hit), .mem_hit(mem_hit));
   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Clock
   always #5 clk_sys = ~clk_sys;
   // Count and report one comparison
   task automatic chk(input logic ok, input string what);
      checks++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask
   // One request; leaves the answer cycle open for checking
   task automatic go(input logic [2:0] rt, input logic [2:0] bs, input logic ov, input logic [2:0] os,
                     input logic [31:0] off);
      ref_type = rt;
      base_reg = bs;
      ovr_valid = ov;
      ovr_seg = os;
      offset = off;
      req_valid = 1;
      @(posedge clk_sys);
      #1 req_valid = 0;
   endtask
   // Compare the answer, then step past it
   task automatic want(input logic [2:0] seg, input logic [31:0] a, input logic mio);
      chk(addr_valid === 1'b1 && seg_used === seg && addr === a && mem_io_n === mio, "memory answer");
      @(posedge clk_sys);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Fixed segments ignore any prefix
   task automatic s_fixed;
      go(REF_CODE, 3'h0, 1, SEG_DATA, 32'h100);
      want(SEG_CODE, 32'h100, 1);
      go(REF_PUSH, 3'h0, 1, SEG_EXTRA, 32'h200);
      want(SEG_STACK, 32'h200, 1);
      go(REF_POP, 3'h0, 1, SEG_DATA, 32'h204);
      want(SEG_STACK, 32'h204, 1);
      go(REF_STRDST, 3'h7, 1, SEG_DATA, 32'h300);
      want(SEG_EXTRA, 32'h300, 1);
   endtask
   // Default segment follows the base register, prefixes replace it
   task automatic s_data;
      go(REF_DATA, 3'h0, 0, SEG_EXTRA, 32'h10);
      want(SEG_DATA, 32'h10, 1);
      go(REF_DATA, BASE_FRAME, 0, SEG_EXTRA, 32'h14);
      want(SEG_STACK, 32'h14, 1);
      go(REF_DATA, BASE_STACK, 0, SEG_EXTRA, 32'h18);
      want(SEG_STACK, 32'h18, 1);
      go(REF_DATA, BASE_FRAME, 1, SEG_EXTRA2, 32'h1c);
      want(SEG_EXTRA2, 32'h1c, 1);
      go(REF_DATA, 3'h1, 1, SEG_EXTRA3, 32'h20);
      want(SEG_EXTRA3, 32'h20, 1);
   endtask
   // Real mode shifts the selector; limits go down to one byte
   task automatic s_real_limit;
      real_mode = 1;
      go(REF_DATA, BASE_FRAME, 0, SEG_EXTRA, 32'h10);
      want(SEG_STACK, 32'h00022230, 1);
      real_mode = 0;
      limit_all[32*SEG_DATA+:32] = 32'h0;
      go(REF_DATA, 3'h0, 0, SEG_EXTRA, 32'h1);
      chk(limit_fault === 1'b1, "fault past one-byte limit");
      want(SEG_DATA, 32'h1, 1);
      go(REF_DATA, 3'h0, 0, SEG_EXTRA, 32'h0);
      chk(limit_fault === 1'b0, "fault inside limit");
      want(SEG_DATA, 32'h0, 1);
   endtask
   // I/O ports bypass translation, zero-extended, select pin low
   task automatic s_io;
      port_from_imm = 1;
      port_imm = 8'h60;
      go(REF_IO, 3'h0, 1, SEG_DATA, 32'hffff_ffff);
      chk(addr_valid === 1'b1 && addr === 32'h0000_0060 && mem_io_n === 1'b0, "imm port");
      @(posedge clk_sys);
      #1 chk(io_hit === 1'b1 && mem_hit === 1'b0, "port decode");
      port_from_imm = 0;
      port_index_reg = 16'hfff8;
      go(REF_IO, 3'h0, 0, SEG_DATA, 32'hffff_ffff);
      chk(addr === 32'h0000_fff8 && mem_io_n === 1'b0 && rsvd_port === 1'b0, "index port");
      @(posedge clk_sys);
      #1;
   endtask
   // Reserved port, clock-enable freeze, mid-run reset, protected base
   task automatic s_misc;
      port_from_imm = 1;
      port_imm = 8'hf8;
      go(REF_IO, 3'h0, 0, SEG_DATA, 32'h0);
      chk(addr === 32'h0000_00f8 && rsvd_port === 1'b1, "reserved port flag");
      @(posedge clk_sys);
      #1 chk(io_hit === 1'b0, "reserved port not decoded");
      ce = 0;
      go(REF_CODE, 3'h0, 0, SEG_DATA, 32'h40);
      ce = 1;
      chk(addr_valid === 1'b0 && addr === 32'h0000_00f8 && mem_io_n === 1'b0, "frozen by clock enable");
      rst = 1;
      @(posedge clk_sys);
      #1 chk(addr_valid === 1'b0 && addr === 32'h0 && mem_io_n === 1'b1 && seg_used === SEG_CODE, "reset values");
      rst = 0;
      go(REF_CODE, 3'h0, 0, SEG_DATA, 32'h44);
      want(SEG_CODE, 32'h44, 1);
      base_all[32*SEG_DATA+:32] = 32'h0001_0000;
      limit_all[32*SEG_DATA+:32] = 32'hffff_ffff;
      go(REF_DATA, 3'h0, 0, SEG_EXTRA, 32'h20);
      want(SEG_DATA, 32'h0001_0020, 1);
      go(REF_DATA, 3'h0, 1, SEG_CODE, 32'h4);
      want(SEG_CODE, 32'h4, 1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Verdict
   task automatic tally_and_finish;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (20) @(posedge clk_sys);
      #1 rst = 0;
      s_fixed();
      s_data();
      s_real_limit();
      s_io();
      s_misc();
      tally_and_finish();
   end
   // Watchdog
   initial begin
      #5000;
      fail_count++;
      tally_and_finish();
   end
endmodule // tb
